// ### pkg/gdl_pkg.sv
/*
 * Shared constants for the gamma DAC double-buffer load path: channel
 * map, code widths, serial bus framing and bus timing.
 * Assumes one 250 MHz system clock at both ends of the two-wire link.
 */
package gdl_pkg;

    // ------------------------------------------------------------
    // channel map and codes
    // ------------------------------------------------------------
    localparam int         NUM_CH     = 20;
    localparam int         DAC_W      = 10;
    localparam int         CH_W       = 5;
    localparam logic [4:0] CH_LAST    = 5'h13;
    localparam logic [9:0] DAC_MID    = 10'h200;
    localparam int         XFER_BIT   = 7;      // bit 15 of the word, bit 7 of the high byte

    // ------------------------------------------------------------
    // bus framing
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR   = 7'h4A;  // arbitrary value
    localparam logic [3:0] ACK_SLOT   = 4'h8;
    localparam logic [3:0] ACK_DONE   = 4'h9;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         MCLK_HZ    = 250_000_000;
    localparam int         SCL_HZ     = 400_000;
    localparam int         QTR_CYC    = MCLK_HZ / (SCL_HZ * 4);

endpackage : gdl_pkg

// ### pkg/gdl_if.sv
/*
 * Two-wire link between the controller end and the DAC end, plus the
 * active-low hardware load line.
 * Assumes both ends share mclk_in; the data wire is open drain and its
 * level is resolved here from both output enables (low enable = drive).
 */
`timescale 1ns/1ps
interface gdl_if;
    logic scl;
    logic sda_m_out;
    logic sda_m_oen;
    logic sda_s_out;
    logic sda_s_oen;
    logic output_load_pin_n;
    logic sda;

    // wired-and with pull-up
    assign sda = (sda_m_oen | sda_m_out) & (sda_s_oen | sda_s_out);

    modport host (
        output scl,
        output sda_m_out,
        output sda_m_oen,
        output output_load_pin_n,
        input  sda
    );

    modport dev (
        input  scl,
        input  sda,
        input  output_load_pin_n,
        output sda_s_out,
        output sda_s_oen
    );
endinterface : gdl_if

// ### src/gdl_dev.sv
/*
 * DAC end: two-wire write slave feeding a two-stage register bank of
 * twenty 10-bit channels; the active stage drives the converters.
 * Assumes the link wires and the load line are asynchronous to mclk_in
 * and that the controller keeps bus timing well above four clocks.
 */
`timescale 1ns/1ps

module gdl_dev (
    input  wire logic                                    mclk_in,    // system clock
    input  wire logic                                    resetn_in,  // async reset, low
    gdl_if.dev                                           bus,        // link to controller
    output logic [gdl_pkg::NUM_CH*gdl_pkg::DAC_W-1:0]    dac_out     // active codes, ch0 low
);

    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_REG  = 3'b010,
        ST_HI   = 3'b011,
        ST_LO   = 3'b100,
        ST_SKIP = 3'b101
    } gdl_dst_t;

    gdl_dst_t                        state_r;
    gdl_dst_t                        state_nxt;
    logic [2:0]                      scl_sy_r;
    logic [2:0]                      sda_sy_r;
    logic [1:0]                      ld_sy_r;
    logic [7:0]                      sh_r;
    logic [3:0]                      bit_r;
    logic                            ack_r;
    logic                            ack_nxt;
    logic                            drv_r;
    logic [gdl_pkg::CH_W-1:0]        ch_r;
    logic [7:0]                      hi_r;
    logic [gdl_pkg::DAC_W-1:0]       in_r  [gdl_pkg::NUM_CH];
    logic [gdl_pkg::DAC_W-1:0]       act_r [gdl_pkg::NUM_CH];

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_sy_r <= 3'h7;
            sda_sy_r <= 3'h7;
            ld_sy_r  <= 2'h3;
        end else begin
            scl_sy_r <= {scl_sy_r[1:0], bus.scl};
            sda_sy_r <= {sda_sy_r[1:0], bus.sda};
            ld_sy_r  <= {ld_sy_r[0], bus.output_load_pin_n};
        end
    end

    // stage [1] is the settled sample; [2] is its one-cycle history
    wire scl_now   = scl_sy_r[1];
    wire scl_was   = scl_sy_r[2];
    wire sda_now   = sda_sy_r[1];
    wire sda_was   = sda_sy_r[2];
    wire load_n    = ld_sy_r[1];
    wire scl_rise  = scl_now & ~scl_was;
    wire scl_fall  = ~scl_now & scl_was;
    wire bus_start = scl_now & scl_was & sda_was & ~sda_now;
    wire bus_stop  = scl_now & scl_was & ~sda_was & sda_now;

    // ------------------------------------------------------------
    // byte decode
    // ------------------------------------------------------------
    wire [7:0] byte_w    = {sh_r[6:0], sda_now};
    wire       byte_done = scl_rise & (bit_r == 4'h7);
    wire       addr_ok   = (byte_w[7:1] == gdl_pkg::DEV_ADDR) & ~byte_w[0];
    wire       reg_ok    = (byte_w[7:5] == 3'h0) & (byte_w[4:0] <= gdl_pkg::CH_LAST);
    // commit only on the completed low byte; a stop or start before it drops the word
    wire       wr_en     = byte_done & (state_r == ST_LO);
    wire       xfer_sw   = wr_en & hi_r[gdl_pkg::XFER_BIT];
    wire [gdl_pkg::DAC_W-1:0] wr_val = {hi_r[1:0], byte_w};

    always_comb begin
        state_nxt = state_r;
        ack_nxt   = ack_r;
        if (byte_done) begin
            unique case (state_r)
                ST_ADDR: begin
                    ack_nxt   = addr_ok;
                    state_nxt = addr_ok ? ST_REG : ST_SKIP;
                end
                ST_REG: begin
                    ack_nxt   = reg_ok;
                    state_nxt = reg_ok ? ST_HI : ST_SKIP;
                end
                ST_HI: begin
                    ack_nxt   = 1'b1;
                    state_nxt = ST_LO;
                end
                ST_LO: begin
                    ack_nxt   = 1'b1;
                    // past the last channel the rest of the burst is refused
                    state_nxt = (ch_r == gdl_pkg::CH_LAST) ? ST_SKIP : ST_HI;
                end
                ST_IDLE,
                ST_SKIP: begin
                    ack_nxt   = 1'b0;
                    state_nxt = state_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // bit engine and protocol state
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ST_IDLE;
            sh_r    <= 8'h00;
            bit_r   <= 4'h0;
            ack_r   <= 1'b0;
            drv_r   <= 1'b0;
        end else if (bus_start) begin
            state_r <= ST_ADDR;
            bit_r   <= 4'h0;
            drv_r   <= 1'b0;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
            bit_r   <= 4'h0;
            drv_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ack_r   <= ack_nxt;
            if (scl_rise && bit_r < gdl_pkg::ACK_SLOT) begin
                sh_r  <= byte_w;
                bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == gdl_pkg::ACK_SLOT) begin
                drv_r <= ack_r;
                bit_r <= gdl_pkg::ACK_DONE;
            end else if (scl_fall && bit_r == gdl_pkg::ACK_DONE) begin
                drv_r <= 1'b0;
                bit_r <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // channel pointer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ch_r <= 5'h00;
            hi_r <= 8'h00;
        end else if (byte_done && state_r == ST_REG) begin
            ch_r <= byte_w[4:0];
        end else if (byte_done && state_r == ST_HI) begin
            hi_r <= byte_w;
        end else if (wr_en && ch_r != gdl_pkg::CH_LAST) begin
            ch_r <= ch_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // two-stage register bank
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < gdl_pkg::NUM_CH; gi++) begin : g_ch
            wire hit = wr_en & (ch_r == 5'(gi));
            wire [gdl_pkg::DAC_W-1:0] in_new = hit ? wr_val : in_r[gi];

            always_ff @(posedge mclk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    in_r[gi]  <= gdl_pkg::DAC_MID;
                    act_r[gi] <= gdl_pkg::DAC_MID;
                end else begin
                    in_r[gi] <= in_new;
                    if (xfer_sw) begin
                        // includes the word whose bit 15 carried the request
                        act_r[gi] <= in_new;
                    end else if (!load_n) begin
                        // level sensitive: follows inputs while the pin stays low
                        act_r[gi] <= in_r[gi];
                    end
                    // otherwise the active code holds
                end
            end

            assign dac_out[gi*gdl_pkg::DAC_W +: gdl_pkg::DAC_W] = act_r[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // open-drain acknowledge
    // ------------------------------------------------------------
    assign bus.sda_s_out = 1'b0;
    assign bus.sda_s_oen = ~drv_r;

endmodule : gdl_dev

// ### src/gdl_host.sv
/*
 * Controller end: issues one single-channel write per command on the
 * two-wire link and drives the load line from a user level.
 * Assumes the DAC end needs no clock stretching; scl is push-pull.
 */
`timescale 1ns/1ps
module gdl_host #(
    parameter int QTR = gdl_pkg::QTR_CYC                     // clocks per quarter bit
) (
    input  wire logic                           mclk_in,      // system clock
    input  wire logic                           resetn_in,    // async reset, low
    gdl_if.host                                 bus,          // link to DAC end
    input  wire logic                           cmd_valid_in, // write request
    output logic                                cmd_ready_out,// idle, request taken
    input  wire logic [gdl_pkg::CH_W-1:0]       cmd_ch_in,    // channel 0..19
    input  wire logic [gdl_pkg::DAC_W-1:0]      cmd_data_in,  // code
    input  wire logic                           cmd_xfer_in,  // set transfer bit
    input  wire logic                           load_in,      // high = hold load pin low
    output logic                                done_out,     // one-cycle pulse at end
    output logic                                nack_out      // last write saw a nack
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_START = 2'b01,
        HS_BIT   = 2'b10,
        HS_STOP  = 2'b11
    } gdl_hst_t;

    gdl_hst_t      state_r;
    logic [15:0]   div_r;
    logic [1:0]    ph_r;
    logic [3:0]    bit_r;
    logic [1:0]    byte_r;
    logic [31:0]   frame_r;
    logic          scl_r;
    logic          sda_r;
    logic          nack_r;
    logic          done_r;
    logic          ld_n_r;
    logic [1:0]    sda_sy_r;

    // ------------------------------------------------------------
    // quarter-bit enable
    // ------------------------------------------------------------
    wire tick = (div_r == 16'(QTR - 1));

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_r    <= 16'h0000;
            sda_sy_r <= 2'h3;
            ld_n_r   <= 1'b1;
        end else begin
            div_r    <= (tick || state_r == HS_IDLE) ? 16'h0000 : div_r + 16'h0001;
            sda_sy_r <= {sda_sy_r[0], bus.sda};
            ld_n_r   <= ~load_in;
        end
    end

    assign cmd_ready_out = (state_r == HS_IDLE);
    wire   take          = cmd_valid_in & cmd_ready_out;
    // high byte: transfer request in bit 15, bit 14 kept clear
    wire [31:0] frame_w  = {gdl_pkg::DEV_ADDR, 1'b0, 3'h0, cmd_ch_in,
                            cmd_xfer_in, 5'h00, cmd_data_in};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= HS_IDLE;
            ph_r    <= 2'h0;
            bit_r   <= 4'h0;
            byte_r  <= 2'h0;
            frame_r <= 32'h0000_0000;
            scl_r   <= 1'b1;
            sda_r   <= 1'b1;
            nack_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (take) begin
                state_r <= HS_START;
                frame_r <= frame_w;
                ph_r    <= 2'h0;
                bit_r   <= 4'h0;
                byte_r  <= 2'h0;
                nack_r  <= 1'b0;
            end else if (tick) begin
                ph_r <= ph_r + 2'h1;
                unique case (state_r)
                    HS_IDLE: ;
                    HS_START: begin
                        if (ph_r == 2'h0) sda_r <= 1'b0;
                        if (ph_r == 2'h1) begin
                            scl_r   <= 1'b0;
                            ph_r    <= 2'h0;
                            state_r <= HS_BIT;
                        end
                    end
                    HS_BIT: begin
                        unique case (ph_r)
                            2'h0: sda_r <= (bit_r < gdl_pkg::ACK_SLOT) ? frame_r[31] : 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: if (bit_r == gdl_pkg::ACK_SLOT) nack_r <= nack_r | sda_sy_r[1];
                            2'h3: begin
                                scl_r <= 1'b0;
                                if (bit_r == gdl_pkg::ACK_SLOT) begin
                                    bit_r  <= 4'h0;
                                    byte_r <= byte_r + 2'h1;
                                    if (byte_r == 2'h3) state_r <= HS_STOP;
                                end else begin
                                    bit_r   <= bit_r + 4'h1;
                                    frame_r <= {frame_r[30:0], 1'b0};
                                end
                            end
                        endcase
                    end
                    HS_STOP: begin
                        unique case (ph_r)
                            2'h0: sda_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_r <= 1'b1;
                            2'h3: begin
                                state_r <= HS_IDLE;
                                done_r  <= 1'b1;
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    assign bus.scl               = scl_r;
    assign bus.sda_m_out         = 1'b0;
    assign bus.sda_m_oen         = sda_r;
    assign bus.output_load_pin_n = ld_n_r;
    assign done_out              = done_r;
    assign nack_out              = nack_r;

endmodule : gdl_host

// ### dv/gdl_props.sv
/*
 * Checker for the two-wire link and the active DAC codes.
 * Assumes it sits beside the link interface, with the host built at QTR.
 */
`timescale 1ns/1ps
module gdl_props #(
    parameter int QTR = 8                                   // clocks per quarter bit
) (
    input wire logic         mclk_in,           // system clock
    input wire logic         resetn_in,         // async reset, low
    input wire logic         scl,               // link clock
    input wire logic         sda,               // resolved data wire
    input wire logic         sda_s_oen,         // dac end drive enable, low
    input wire logic         output_load_pin_n, // hardware load line
    input wire logic [199:0] dac_out            // active codes
);
    // ------------------------------------------------------------
    // bounds
    // ------------------------------------------------------------
    localparam int ACK_MIN = 3 * QTR;
    localparam int ACK_MAX = 5 * QTR;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    // ------------------------------------------------------------
    // active stage
    // ------------------------------------------------------------
    a_reset_mid_scale: assert property ($rose(resetn_in) |->
        dac_out == {gdl_pkg::NUM_CH{gdl_pkg::DAC_MID}})
        else $error("active codes not mid-scale after reset");
    // sync lag of the load line is covered by looking six clocks back
    a_active_hold: assert property ($changed(dac_out) |->
        scl || !output_load_pin_n || !$past(output_load_pin_n, 6))
        else $error("active codes moved without a transfer");
    a_after_last_bit: assert property (($changed(dac_out) && output_load_pin_n
        && $past(output_load_pin_n, 6)) |-> $past(scl, 1) && !$past(scl, 8))
        else $error("software transfer not tied to a clock rise");
    a_update_once: assert property (($changed(dac_out) && output_load_pin_n
        && $past(output_load_pin_n, 6)) |=> $stable(dac_out)[*8])
        else $error("software transfer split over several edges");

    // ------------------------------------------------------------
    // acknowledge
    // ------------------------------------------------------------
    a_ack_after_fall: assert property ($fell(sda_s_oen) |-> !scl && $past(scl, 6))
        else $error("acknowledge not started in the low phase");
    // the resolved wire must carry the answer, not only the enable
    a_ack_held_low: assert property ($fell(sda_s_oen) |-> (!sda_s_oen && !sda)[*8])
        else $error("acknowledge too short");
    a_ack_released: assert property ($fell(sda_s_oen) |-> ##[ACK_MIN:ACK_MAX] sda_s_oen)
        else $error("acknowledge not released in time");
    a_ack_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oen))
        else $error("dac end moved the wire while the clock was high");
endmodule : gdl_props

// ### dv/test_gamma_dac_double_buffer_load.sv
/*
 * Bench: host end and dac end joined by the link, against a model of
 * both register stages. Assumes QTR of 8 for a short run.
 */
`timescale 1ns/1ps
module test_gamma_dac_double_buffer_load;
    logic         mclk_in;
    logic         resetn_in;
    logic         cmd_valid;
    logic         cmd_xfer;
    logic         load;
    logic         ready;
    logic         done;
    logic         nack;
    logic [4:0]   cmd_ch;
    logic [9:0]   cmd_data;
    logic [199:0] dac;
    int           fails;
    int           checks;
    int           seed;
    int           inp[20];
    int           act[20];

    gdl_if link();
    gdl_host #(.QTR(8)) gdl_host_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .bus(link), .cmd_valid_in(cmd_valid), .cmd_ready_out(ready), .cmd_ch_in(cmd_ch),
        .cmd_data_in(cmd_data), .cmd_xfer_in(cmd_xfer), .load_in(load),
        .done_out(done), .nack_out(nack));
    gdl_dev gdl_dev_inst (.mclk_in(mclk_in), .resetn_in(resetn_in), .bus(link),
        .dac_out(dac));
    gdl_props #(.QTR(8)) gdl_props_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .scl(link.scl), .sda(link.sda), .sda_s_oen(link.sda_s_oen),
        .output_load_pin_n(link.output_load_pin_n), .dac_out(dac));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [199:0] exp_dac();
        logic [199:0] v;
        for (int i = 0; i < 20; i++) begin
            v[i*10 +: 10] = act[i][9:0];
        end
        return v;
    endfunction : exp_dac

    task automatic conclude();
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [199:0] e, input logic [199:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // one single-channel write; model updates only on a whole valid word
    task automatic wr(input int ch, input int d, input bit x);
        int n;
        n = 0;
        @(negedge mclk_in);
        while (ready !== 1'b1 && n < 3000) begin
            @(negedge mclk_in);
            n++;
        end
        @(posedge mclk_in);
        cmd_valid <= 1'b1;
        cmd_ch    <= ch[4:0];
        cmd_data  <= d[9:0];
        cmd_xfer  <= x;
        @(posedge mclk_in);
        cmd_valid <= 1'b0;
        do begin
            @(negedge mclk_in);
            n++;
        end while (done !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            fails++;
            conclude();
        end
        if (ch < 20) begin
            inp[ch] = d;
            if (x) begin
                act = inp;
            end
        end
        chk("nack", {199'h0, ch > 19}, {199'h0, nack});
        chk("dac", exp_dac(), dac);
    endtask : wr

    task automatic pulse_load();
        @(posedge mclk_in);
        load <= 1'b1;
        repeat (10) @(posedge mclk_in);
        load <= 1'b0;
        repeat (8) @(posedge mclk_in);
        act = inp;
        @(negedge mclk_in);
        chk("dac after load", exp_dac(), dac);
    endtask : pulse_load

    // ------------------------------------------------------------
    // clock and sequence
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    initial begin
        seed      = 73020;
        fails     = 0;
        checks    = 0;
        resetn_in = 1'b0;
        cmd_valid = 1'b0;
        cmd_xfer  = 1'b0;
        cmd_ch    = 5'h00;
        cmd_data  = 10'h000;
        load      = 1'b0;
        foreach (inp[i]) begin
            inp[i] = gdl_pkg::DAC_MID;
            act[i] = gdl_pkg::DAC_MID;
        end
        repeat (20) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(negedge mclk_in);
        chk("dac at reset", exp_dac(), dac);
        chk("idle wire", 200'h7,
            {197'h0, link.scl, link.sda, link.output_load_pin_n});
        pulse_load();
        for (int c = 0; c < 20; c++) begin
            wr(c, $random(seed) & 32'h0000_03FF, 1'b0);
        end
        wr(5, inp[5], 1'b1);
        for (int c = 0; c < 18; c++) begin
            wr(c, $random(seed) & 32'h0000_03FF, c == 17);
        end
        wr(20, $random(seed) & 32'h0000_03FF, 1'b1);
        wr(31, $random(seed) & 32'h0000_03FF, 1'b1);
        wr(18, $random(seed) & 32'h0000_03FF, 1'b0);
        wr(19, $random(seed) & 32'h0000_03FF, 1'b0);
        pulse_load();
        wr(19, 32'h0000_03FF, 1'b0);
        wr(0, 32'h0000_0000, 1'b1);
        // mid-run reset: stale input codes must not reach a later load
        @(posedge mclk_in);
        resetn_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        resetn_in <= 1'b1;
        foreach (inp[i]) begin
            inp[i] = gdl_pkg::DAC_MID;
            act[i] = gdl_pkg::DAC_MID;
        end
        @(negedge mclk_in);
        chk("dac after reset", exp_dac(), dac);
        pulse_load();
        wr(3, $random(seed) & 32'h0000_03FF, 1'b1);
        conclude();
    end
endmodule : test_gamma_dac_double_buffer_load
